// *** rtl/ltc_hold_filter.v ***
// level filter: output follows input only after it has held for a count
module ltc_hold_filter #(
  parameter INIT = 1'b0
) (
  // clock and reset
  input wire sysClk,
  input wire resetn,
  // synced level and hold counts
  input wire d,
  input wire [23:0] riseCnt,
  input wire [23:0] fallCnt,
  // filtered level and its edges
  output reg q,
  output reg rise,
  output reg fall
);
  reg [23:0] cnt;
  wire [23:0] target;

  assign target = d ? riseCnt : fallCnt;

  always @(posedge sysClk) begin
    if (!resetn) begin
      q <= INIT;
      cnt <= 24'h0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (d == q) begin
        // a glitch back restarts the hold time
        cnt <= 24'h0;
      end else if (cnt + 24'h1 >= target) begin
        q <= d;
        cnt <= 24'h0;
        rise <= d;
        fall <= ~d;
      end else begin
        cnt <= cnt + 24'h1;
      end
    end
  end
endmodule // ltc_hold_filter

// *** rtl/ltc_regs.vh ***
// constants for the lin transceiver mode and wake controller
`ifndef LTC_REGS_VH
`define LTC_REGS_VH

// ----------------------------------------
// clock
// ----------------------------------------
`define LTC_CLK_MHZ 250

// ----------------------------------------
// timing, in nanoseconds (plain defaults), power-up delay in clock cycles
// ----------------------------------------
`define LTC_T_DOM_NS 6000000
`define LTC_T_GOTOSLEEP_NS 10000
`define LTC_T_GOTONORM_NS 10000
`define LTC_T_WAKE_LIN_NS 100000
`define LTC_T_WAKE_LOCAL_NS 100000
`define LTC_PWRUP_CYC 2'h3

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define LTC_CTRL_OFS 12'h000
`define LTC_STAT_OFS 12'h004

// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define LTC_CTRL_TXOFF 0
`define LTC_CTRL_WAKEEN 1
`define LTC_CTRL_RST 2'h2

// ----------------------------------------
// status fields
// ----------------------------------------
`define LTC_STAT_MODE_LO 0
`define LTC_STAT_WSRC 2
`define LTC_STAT_WREQ 3
`define LTC_STAT_DOMTO 4
`define LTC_STAT_THERM 5
`define LTC_STAT_SLP 6
`define LTC_STAT_DRV 7

`endif

// *** rtl/ltc_sync2.v ***
// two-flop synchroniser for a group of slow pins
module ltc_sync2 #(
  parameter W = 4,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire sysClk,
  input wire resetn,
  // pins and synced copy
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge sysClk) begin
    if (!resetn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // ltc_sync2

// *** rtl/ltc_transceiver.v ***
// lin transceiver mode, wake and driver control with apb status access
//
// Overview of operation
// - falling txd edge starts dominant timer
// - txd low past timeout disables transmitter
// - rising txd edge clears dominant timer
// - overtemperature in normal disables bus driver
// - driver back after cool and txd high
// - sleep entered only from normal, sleep low
// - sleep only after full go-to-sleep hold
// - inhibit floats in sleep, high otherwise
// - valid wake in sleep moves to standby
// - standby drives rxd low as wake request
// - sleep-control high clears wake source at once
// - sleep-control high clears wake request at once
// - normal after go-to-normal hold of high
// - transmitter and receiver active only in normal
// - high bus recessive, low bus dominant
// - power-on floats rxd, weak txd pull-down
// - power-up goes normal if high, else standby
// - txd pull-down strength shows wake source
// - wake and sleep-control inputs are hold filtered
// - local wake only on falling edge
// - no battery floats rxd, stops driver
// - undriven sleep-control and txd read low
// - remote wake needs fall, long low, rise
// - valid wake raises inhibit, termination on
`include "ltc_regs.vh"

module ltc_transceiver #(
  parameter [31:0] DOM_CYC = (`LTC_T_DOM_NS * `LTC_CLK_MHZ + 999) / 1000,
  parameter [31:0] SLEEP_CYC = (`LTC_T_GOTOSLEEP_NS * `LTC_CLK_MHZ + 999) / 1000,
  parameter [31:0] NORM_CYC = (`LTC_T_GOTONORM_NS * `LTC_CLK_MHZ + 999) / 1000,
  parameter [31:0] WLIN_CYC = (`LTC_T_WAKE_LIN_NS * `LTC_CLK_MHZ + 999) / 1000,
  parameter [31:0] WLOC_CYC = (`LTC_T_WAKE_LOCAL_NS * `LTC_CLK_MHZ + 999) / 1000
) (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // host side pins
  input wire txdIn,
  input wire sleepCtrlN,
  input wire wakeLocalN,
  output reg rxdOut,
  output reg rxdOe,
  output reg txdOut,
  output reg txdStrongOe,
  output reg txdWeakPd,
  // bus side
  input wire busIn,
  output reg busDrvDom,
  output reg termOn,
  // supply and protection
  input wire overTemp,
  input wire batteryOk,
  output reg regulatorInhibitOut,
  output reg regulatorInhibitOe
);

  // ----------------------------------------
  // modes
  // ----------------------------------------
  localparam [1:0] MODE_PWRON = 2'h0;
  localparam [1:0] MODE_SLEEP = 2'h1;
  localparam [1:0] MODE_STBY = 2'h2;
  localparam [1:0] MODE_NORM = 2'h3;

  // ----------------------------------------
  // cycle counts
  // ----------------------------------------
  wire [23:0] domCyc = DOM_CYC[23:0];
  wire [23:0] sleepCyc = SLEEP_CYC[23:0];
  wire [23:0] normCyc = NORM_CYC[23:0];
  wire [23:0] wlinCyc = WLIN_CYC[23:0];
  wire [23:0] wlocCyc = WLOC_CYC[23:0];

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [1:0] mode;
  reg [1:0] next_mode;
  reg [1:0] pwrCnt;
  reg [1:0] ctrl;
  reg wakeSrcLocal;
  reg wakeReq;
  reg remoteArmed;
  reg txdPrev;
  reg domRun;
  reg domTimeout;
  reg [23:0] domCnt;
  reg thermOff;
  reg [31:0] statWord;
  wire [4:0] syncQ;
  wire txdSync;
  wire slpSync;
  wire wakeSync;
  wire busSync;
  wire batSync;
  wire slpFilt;
  wire slpFall;
  wire wakeFilt;
  wire wakeFall;
  wire busFilt;
  wire busRise;
  wire busFall;
  wire txdFallEdge;
  wire txdRiseEdge;
  wire localWake;
  wire remoteWake;
  wire anyWake;
  wire drvAllowed;
  wire apbWrite;
  wire apbSetup;

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  // reset to low so that an unsettled sleep or txd pin reads as low
  ltc_sync2 #(
    .W(5),
    .INIT(5'h0c)
  ) uSync (
    .sysClk(sys_clk),
    .resetn(resetn),
    .d({batteryOk, busIn, wakeLocalN, sleepCtrlN, txdIn}),
    .q(syncQ)
  );

  assign txdSync = syncQ[0];
  assign slpSync = syncQ[1];
  assign wakeSync = syncQ[2];
  assign busSync = syncQ[3];
  assign batSync = syncQ[4];

  // ----------------------------------------
  // hold filters
  // ----------------------------------------
  // sleep-control: high must hold go-to-normal, low must hold go-to-sleep
  ltc_hold_filter #(
    .INIT(1'b0)
  ) uSlpFilt (
    .sysClk(sys_clk),
    .resetn(resetn),
    .d(slpSync),
    .riseCnt(normCyc),
    .fallCnt(sleepCyc),
    .q(slpFilt),
    .rise(),
    .fall(slpFall)
  );

  // local wake: only the low level is qualified
  ltc_hold_filter #(
    .INIT(1'b1)
  ) uWakeFilt (
    .sysClk(sys_clk),
    .resetn(resetn),
    .d(wakeSync),
    .riseCnt(24'h1),
    .fallCnt(wlocCyc),
    .q(wakeFilt),
    .rise(),
    .fall(wakeFall)
  );

  // bus: dominant must outlast the remote wake time
  ltc_hold_filter #(
    .INIT(1'b1)
  ) uBusFilt (
    .sysClk(sys_clk),
    .resetn(resetn),
    .d(busSync),
    .riseCnt(24'h1),
    .fallCnt(wlinCyc),
    .q(busFilt),
    .rise(busRise),
    .fall(busFall)
  );

  // ----------------------------------------
  // wake detection
  // ----------------------------------------
  // a wake pin held low at sleep entry gives no edge, so no wake
  assign localWake = wakeFall & ~wakeFilt;
  assign remoteWake = remoteArmed & busRise;
  assign anyWake = (mode == MODE_SLEEP) & ctrl[`LTC_CTRL_WAKEEN] &
                   (localWake | remoteWake);

  always @(posedge sys_clk) begin
    if (!resetn) begin
      remoteArmed <= 1'b0;
    end else if (mode != MODE_SLEEP) begin
      remoteArmed <= 1'b0;
    end else if (busFall) begin
      // fall plus qualified low seen; the rise completes it
      remoteArmed <= 1'b1;
    end else if (busRise) begin
      remoteArmed <= 1'b0;
    end
  end

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  always @* begin
    next_mode = mode;
    case (mode)
      MODE_PWRON: begin
        if (pwrCnt == `LTC_PWRUP_CYC) begin
          next_mode = slpSync ? MODE_NORM : MODE_STBY;
        end
      end
      MODE_SLEEP: begin
        if (slpFilt) begin
          next_mode = MODE_NORM;
        end else if (anyWake) begin
          next_mode = MODE_STBY;
        end
      end
      MODE_STBY: begin
        if (slpFilt) begin
          next_mode = MODE_NORM;
        end
      end
      MODE_NORM: begin
        // filter fall pulse means low held for the whole go-to-sleep time
        if (slpFall) begin
          next_mode = MODE_SLEEP;
        end
      end
      default: begin
        next_mode = MODE_PWRON;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      mode <= MODE_PWRON;
      pwrCnt <= 2'h0;
    end else begin
      mode <= next_mode;
      if (mode == MODE_PWRON) begin
        pwrCnt <= pwrCnt + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // wake source and wake request flags
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!resetn) begin
      wakeSrcLocal <= 1'b0;
      wakeReq <= 1'b0;
    end else begin
      // clear acts on the raw synced level, ahead of the mode change
      if (mode == MODE_STBY && slpSync) begin
        wakeSrcLocal <= 1'b0;
        wakeReq <= 1'b0;
      end
      if (anyWake) begin
        wakeSrcLocal <= localWake;
        wakeReq <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // txd dominant timeout
  // ----------------------------------------
  assign txdFallEdge = txdPrev & ~txdSync;
  assign txdRiseEdge = ~txdPrev & txdSync;

  always @(posedge sys_clk) begin
    if (!resetn) begin
      txdPrev <= 1'b0;
      domRun <= 1'b0;
      domTimeout <= 1'b0;
      domCnt <= 24'h0;
    end else begin
      txdPrev <= txdSync;
      if (txdRiseEdge) begin
        domRun <= 1'b0;
        domTimeout <= 1'b0;
        domCnt <= 24'h0;
      end else if (txdFallEdge) begin
        domRun <= 1'b1;
        domTimeout <= 1'b0;
        domCnt <= 24'h0;
      end else if (domRun && !domTimeout) begin
        if (domCnt + 24'h1 >= domCyc) begin
          domTimeout <= 1'b1;
        end
        domCnt <= domCnt + 24'h1;
      end
    end
  end

  // ----------------------------------------
  // thermal shutdown
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!resetn) begin
      thermOff <= 1'b0;
    end else if (mode == MODE_NORM && overTemp) begin
      thermOff <= 1'b1;
    end else if (!overTemp && txdSync) begin
      // waiting for recessive txd avoids a half bit on release
      thermOff <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  assign drvAllowed = (mode == MODE_NORM) & batSync & ~domTimeout & ~thermOff &
                      ~ctrl[`LTC_CTRL_TXOFF];

  always @(posedge sys_clk) begin
    if (!resetn) begin
      busDrvDom <= 1'b0;
      rxdOut <= 1'b0;
      rxdOe <= 1'b0;
      txdOut <= 1'b0;
      txdStrongOe <= 1'b0;
      txdWeakPd <= 1'b1;
      termOn <= 1'b0;
      regulatorInhibitOut <= 1'b0;
      regulatorInhibitOe <= 1'b0;
    end else begin
      // low txd is dominant, so the driver pulls the bus down
      busDrvDom <= drvAllowed & ~txdSync & (next_mode == MODE_NORM);
      rxdOut <= 1'b0;
      txdOut <= 1'b0;
      case (mode)
        MODE_NORM: begin
          // open drain: low bus pulls rxd low, high bus releases it
          rxdOe <= batSync & ~busSync & (next_mode == MODE_NORM);
          txdStrongOe <= 1'b0;
          txdWeakPd <= 1'b0;
        end
        MODE_STBY: begin
          rxdOe <= batSync & wakeReq;
          txdStrongOe <= wakeSrcLocal;
          txdWeakPd <= 1'b1;
        end
        default: begin
          rxdOe <= 1'b0;
          txdStrongOe <= 1'b0;
          txdWeakPd <= 1'b1;
        end
      endcase
      regulatorInhibitOut <= 1'b1;
      regulatorInhibitOe <= (next_mode != MODE_SLEEP);
      termOn <= (next_mode != MODE_SLEEP);
    end
  end

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready & pwrite;

  always @* begin
    statWord = 32'h0;
    statWord[`LTC_STAT_MODE_LO+1:`LTC_STAT_MODE_LO] = mode;
    statWord[`LTC_STAT_WSRC] = wakeSrcLocal;
    statWord[`LTC_STAT_WREQ] = wakeReq;
    statWord[`LTC_STAT_DOMTO] = domTimeout;
    statWord[`LTC_STAT_THERM] = thermOff;
    statWord[`LTC_STAT_SLP] = slpFilt;
    statWord[`LTC_STAT_DRV] = drvAllowed;
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl <= `LTC_CTRL_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apbSetup) begin
        // answer is latched in setup so it comes straight from a flop
        case (paddr)
          `LTC_CTRL_OFS: begin
            prdata <= {30'h0, ctrl};
            pslverr <= 1'b0;
          end
          `LTC_STAT_OFS: begin
            prdata <= statWord;
            pslverr <= 1'b0;
          end
          default: begin
            prdata <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (apbWrite && paddr == `LTC_CTRL_OFS) begin
        ctrl <= pwdata[1:0];
      end
    end
  end

endmodule // ltc_transceiver

// *** verification/ltc_bus_model.sv ***
// wired-and lin bus with a remote node, plus host pull-up on rxd
module ltc_bus_model (
  // drivers
  input wire busDrvDom,
  input wire remoteDom,
  input wire rxdOe,
  // resolved lines
  output wire busIn,
  output wire rxdPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // pull-up holds recessive unless any node pulls dominant
  assign busIn = !(busDrvDom | remoteDom);
  assign rxdPin = !rxdOe;
endmodule // ltc_bus_model

// *** verification/ltc_transceiver_chk.sv ***
// assertion checker for the transceiver control ports
module ltc_transceiver_chk #(
  parameter [31:0] DOM_CYC = 32'h14,
  parameter [31:0] SLEEP_CYC = 32'h8
) (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // watched pins
  input wire txdIn,
  input wire sleepCtrlN,
  input wire overTemp,
  input wire batteryOk,
  input wire rxdOe,
  input wire txdStrongOe,
  input wire busDrvDom,
  input wire regulatorInhibitOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] domCnt;
  logic [31:0] lowCnt;
  // ------
  // run-length counters
  // ------
  // counters, since long holds cannot be written as repetitions
  always @(posedge sys_clk) begin
    if (!resetn) begin
      domCnt <= 32'h0;
      lowCnt <= 32'h0;
    end else begin
      domCnt <= busDrvDom ? domCnt + 32'h1 : 32'h0;
      lowCnt <= sleepCtrlN ? 32'h0 : lowCnt + 32'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ------
  // properties
  // ------
  property p_sleepHold;
    $fell(regulatorInhibitOe) |-> lowCnt >= SLEEP_CYC;
  endproperty
  a_sleepHold: assert property (p_sleepHold)
    else $error("sleep entered before hold time");
  property p_sleepQuiet;
    !regulatorInhibitOe |-> !busDrvDom && !rxdOe;
  endproperty
  a_sleepQuiet: assert property (p_sleepQuiet)
    else $error("driver or rxd active while inhibit floats");
  property p_domLimit;
    domCnt <= DOM_CYC + 32'h8;
  endproperty
  a_domLimit: assert property (p_domLimit)
    else $error("dominant drive outlived timeout");
  property p_overTemp;
    overTemp [*5] |-> !busDrvDom;
  endproperty
  a_overTemp: assert property (p_overTemp)
    else $error("driver on while overheated");
  property p_battery;
    !batteryOk [*5] |-> !busDrvDom && !rxdOe;
  endproperty
  a_battery: assert property (p_battery)
    else $error("outputs active without battery");
  property p_txdPath;
    busDrvDom |-> !$past(txdIn, 3);
  endproperty
  a_txdPath: assert property (p_txdPath)
    else $error("dominant drive without low txd");
  property p_rxdMirror;
    (busDrvDom && batteryOk) [*5] |-> rxdOe;
  endproperty
  a_rxdMirror: assert property (p_rxdMirror)
    else $error("dominant bus not reported on rxd");
  property p_strongReq;
    txdStrongOe |-> rxdOe;
  endproperty
  a_strongReq: assert property (p_strongReq)
    else $error("local wake flag without wake request");
  property p_wakeClr;
    sleepCtrlN [*6] |-> !txdStrongOe;
  endproperty
  a_wakeClr: assert property (p_wakeClr)
    else $error("wake source flag kept after sleep-control high");
  c_sleep: cover property ($fell(regulatorInhibitOe));
  c_local: cover property ($rose(txdStrongOe));
  c_timeout: cover property (domCnt == DOM_CYC);
endmodule // ltc_transceiver_chk

bind ltc_transceiver ltc_transceiver_chk #(.DOM_CYC(DOM_CYC), .SLEEP_CYC(SLEEP_CYC)) chk (
  .sys_clk(sys_clk), .resetn(resetn), .txdIn(txdIn), .sleepCtrlN(sleepCtrlN),
  .overTemp(overTemp), .batteryOk(batteryOk), .rxdOe(rxdOe), .txdStrongOe(txdStrongOe),
  .busDrvDom(busDrvDom), .regulatorInhibitOe(regulatorInhibitOe));

// *** verification/tb.sv ***
// self-checking bench for the transceiver control block
`include "ltc_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DOMC = 20;
  localparam int SLPC = 8;
  localparam int NRMC = 8;
  localparam int WAKC = 10;
  logic sysClk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'ha5df;
  logic pready, pslverr, err, txdIn = 1'h1, sleepCtrlN = 1'h1, wakeLocalN = 1'h1;
  logic overTemp = 1'h0, batteryOk = 1'h1, remoteDom = 1'h0, busIn, rxdPin;
  logic rxdOut, rxdOe, txdOut, txdStrongOe, txdWeakPd, busDrvDom, termOn;
  logic regulatorInhibitOut, regulatorInhibitOe;
  int errTotal = 0, checksDone = 0;
  always #2 sysClk = ~sysClk;
  // short counts keep the run brief
  ltc_transceiver #(.DOM_CYC(32'h14), .SLEEP_CYC(32'h8), .NORM_CYC(32'h8), .WLIN_CYC(32'ha),
    .WLOC_CYC(32'ha)) uut (
    .sys_clk(sysClk), .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .txdIn, .sleepCtrlN, .wakeLocalN, .rxdOut, .rxdOe, .txdOut, .txdStrongOe,
    .txdWeakPd, .busIn, .busDrvDom, .termOn, .overTemp, .batteryOk, .regulatorInhibitOut,
    .regulatorInhibitOe);
  ltc_bus_model bus (.busDrvDom, .remoteDom, .rxdOe, .busIn, .rxdPin);
  // ------
  // helpers
  // ------
  task tk(input int n);
    repeat (n) @(posedge sysClk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sysClk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1'h1;
    @(posedge sysClk);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge sysClk);
      n++;
    end
    if (n == 20) errTotal++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task mode(input logic [1:0] m);
    apb(1'h0, `LTC_STAT_OFS, 32'h0);
    chk(rd[1:0], m);
  endtask
  task rst(input logic s);
    resetn <= 1'h0;
    sleepCtrlN <= s;
    tk(8);
    resetn <= 1'h1;
    tk(2);
    chk({rxdOe, txdWeakPd, busDrvDom, regulatorInhibitOe}, 4'h5);
    tk(4);
  endtask
  function logic expDom(input logic t, input logic ok);
    return !t && ok;
  endfunction
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task summarize;
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    tk(20000);
    errTotal++;
    summarize;
  end
  // ------
  // scenarios
  // ------
  initial begin
    rst(1'h1);
    mode(2'h3);
    apb(1'h0, `LTC_CTRL_OFS, 32'h0);
    chk(rd, `LTC_CTRL_RST);
    apb(1'h0, 12'h0f0, 32'h0);
    chk(err, 1'h1);
    chk({rxdOut, txdOut, regulatorInhibitOut}, 3'h1);
    apb(1'h1, `LTC_CTRL_OFS, 32'h3);
    txdIn <= 1'h0;
    tk(6);
    chk(busDrvDom, 1'h0);
    apb(1'h0, `LTC_CTRL_OFS, 32'h0);
    chk(rd, 32'h3);
    txdIn <= 1'h1;
    apb(1'h1, `LTC_CTRL_OFS, `LTC_CTRL_RST);
    // txd forced high every other step so random lows never reach the timeout
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      txdIn <= seed[0] | i[0];
      remoteDom <= seed[1];
      tk(7);
      chk(busDrvDom, expDom(txdIn, 1'h1));
      chk(rxdPin, txdIn & !remoteDom);
    end
    remoteDom <= 1'h0;
    txdIn <= 1'h0;
    tk(6);
    chk(busDrvDom, 1'h1);
    tk(DOMC + 8);
    chk(busDrvDom, 1'h0);
    txdIn <= 1'h1;
    tk(4);
    txdIn <= 1'h0;
    tk(6);
    chk(busDrvDom, 1'h1);
    overTemp <= 1'h1;
    tk(5);
    chk(busDrvDom, 1'h0);
    overTemp <= 1'h0;
    tk(5);
    chk(busDrvDom, 1'h0);
    txdIn <= 1'h1;
    tk(4);
    txdIn <= 1'h0;
    batteryOk <= 1'h0;
    remoteDom <= 1'h1;
    tk(6);
    chk({busDrvDom, rxdOe}, 2'h0);
    batteryOk <= 1'h1;
    remoteDom <= 1'h0;
    tk(6);
    chk(busDrvDom, 1'h1);
    txdIn <= 1'h1;
    sleepCtrlN <= 1'h0;
    tk(SLPC - 4);
    sleepCtrlN <= 1'h1;
    tk(8);
    chk(regulatorInhibitOe, 1'h1);
    sleepCtrlN <= 1'h0;
    tk(SLPC + 8);
    chk(regulatorInhibitOe, 1'h0);
    mode(2'h1);
    apb(1'h1, `LTC_CTRL_OFS, 32'h0);
    wakeLocalN <= 1'h0;
    tk(WAKC + 8);
    wakeLocalN <= 1'h1;
    chk(regulatorInhibitOe, 1'h0);
    apb(1'h1, `LTC_CTRL_OFS, `LTC_CTRL_RST);
    tk(2);
    wakeLocalN <= 1'h0;
    tk(WAKC + 8);
    wakeLocalN <= 1'h1;
    chk({regulatorInhibitOe, termOn, rxdPin, txdStrongOe}, 4'hd);
    mode(2'h2);
    sleepCtrlN <= 1'h1;
    tk(5);
    chk({txdStrongOe, rxdOe}, 2'h0);
    tk(NRMC + 6);
    mode(2'h3);
    sleepCtrlN <= 1'h0;
    tk(SLPC + 8);
    remoteDom <= 1'h1;
    tk(WAKC + 6);
    chk(regulatorInhibitOe, 1'h0);
    remoteDom <= 1'h0;
    tk(6);
    chk({regulatorInhibitOe, rxdPin, txdStrongOe, txdWeakPd}, 4'h9);
    rst(1'h0);
    mode(2'h2);
    tk(SLPC + 8);
    mode(2'h2);
    summarize;
  end
endmodule // tb
